// ===== uem_regs.sv
// module: uncorrectable error mask and severity registers with report gating
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - masked error sets nothing, sends nothing, logs nothing
// - mask word at 108h, resets zero
// - mask 31:22, 11:6, 3:0 read zero
// - mask bit 21 always reads zero
// - mask bit 5 always reads zero
// - mask 20:18 writable, reset unmasked
// - mask 17:15 writable, reset unmasked
// - mask 14:12 and 4 writable, reset unmasked
// - three resets restore all writable defaults
// - severity one fatal, zero nonfatal message
// - severity word at 10Ch
// - severity resets to 0006 2031h
// - severity 20:12 and 4 writable selectors
// - severity bit 21 reads zero
// - severity bit 5 reads one
// - severity 31:22, 11:6 read zero
// - severity 3:1 read zero
// - severity bit 0 reads one
// - each bit governs same status position
module uem_regs (
  // clock and local reset
  input wire logic clk_sys,
  input wire logic reset,
  // reset pins from outside the clock domain
  input wire logic link_fundamental_reset,
  input wire logic global_reset_input,
  input wire logic power_on_reset,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_valid,
  // error detectors, one pulse per error position
  input wire logic [31:0] err_detect,
  // reports toward status, message, log and pointer logic
  output logic [31:0] status_set,
  output logic fatal_msg,
  output logic nonfatal_msg,
  output logic header_log_load,
  output logic first_ptr_load,
  output logic [4:0] first_ptr
);

  // ****************************************
  // reset synchronisers
  // ****************************************
  logic [2:0] pin_meta;        // first stage, read only by second stage
  logic [2:0] pin_sync;        // second stage
  logic block_reset;           // combined reset of all register state except the two synchroniser stages
  logic [2:0] next_pin_meta;
  logic [2:0] next_pin_sync;

  // pins are asynchronous to clk_sys, so two flops before use
  always_comb begin
    next_pin_meta = {power_on_reset, global_reset_input, link_fundamental_reset};
    next_pin_sync = pin_meta;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
    end
  end

  // any of the three resets, or the local one, restores defaults
  assign block_reset = reset | (|pin_sync);

  // ****************************************
  // write decode
  // ****************************************
  logic [31:0] lane_mask;      // byte enables widened to bits
  logic hit_suppress;          // access addresses the mask word
  logic hit_fatality;          // access addresses the severity word

  // one lane of enables per byte
  for (genvar g = 0; g < uem_pkg::LANE_COUNT; g++) begin : g_lane
    assign lane_mask[g*8 +: 8] = cfg_be[g] ? uem_pkg::LANE_ONES : uem_pkg::LANE_ZERO;
  end

  assign hit_suppress = (cfg_addr == uem_pkg::SUPPRESS_OFFSET);
  assign hit_fatality = (cfg_addr == uem_pkg::FATALITY_OFFSET);

  // ****************************************
  // register state
  // ****************************************
  logic [31:0] suppress_bits;  // only writable positions are ever non-zero
  logic [31:0] fatality_bits;  // writable positions only; fixed ones added on read
  logic [31:0] next_suppress_bits;
  logic [31:0] next_fatality_bits;
  logic [31:0] write_gate;     // bits a write may change this cycle

  // read-only positions are cut out of the write gate, so writes there vanish
  always_comb begin
    write_gate = lane_mask & uem_pkg::WRITABLE_BITS;
    next_suppress_bits = suppress_bits;
    next_fatality_bits = fatality_bits;
    if (cfg_wr && hit_suppress) begin
      next_suppress_bits = (suppress_bits & ~write_gate) | (cfg_wdata & write_gate);
    end
    if (cfg_wr && hit_fatality) begin
      next_fatality_bits = (fatality_bits & ~write_gate) | (cfg_wdata & write_gate);
    end
  end

  // stored fatality excludes the constant ones so they cannot be lost
  always_ff @(posedge clk_sys) begin
    if (block_reset) begin
      suppress_bits <= uem_pkg::SUPPRESS_RESET;
      fatality_bits <= uem_pkg::FATALITY_RESET & uem_pkg::WRITABLE_BITS;
    end else begin
      suppress_bits <= next_suppress_bits;
      fatality_bits <= next_fatality_bits;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [31:0] suppress_view;  // software view of the mask word
  logic [31:0] fatality_view;  // software view of the severity word
  logic [31:0] next_cfg_rdata;
  logic next_cfg_rd_valid;

  // reserved and unsupported bits are never stored, so they read zero
  assign suppress_view = suppress_bits & uem_pkg::WRITABLE_BITS;
  // fixed ones of bits 5 and 0 are or-ed in on every read, never stored
  assign fatality_view = (fatality_bits & uem_pkg::WRITABLE_BITS)
    | uem_pkg::FATALITY_FIXED_ONES;

  // unmapped offsets answer zero rather than stale data
  always_comb begin
    next_cfg_rd_valid = cfg_rd;
    next_cfg_rdata = uem_pkg::WORD_ZERO;
    if (cfg_rd && hit_suppress) begin
      next_cfg_rdata = suppress_view;
    end else if (cfg_rd && hit_fatality) begin
      next_cfg_rdata = fatality_view;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (block_reset) begin
      cfg_rdata <= uem_pkg::WORD_ZERO;
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rdata <= next_cfg_rdata;
      cfg_rd_valid <= next_cfg_rd_valid;
    end
  end

  // ****************************************
  // error report gating
  // ****************************************
  // current register values steer the reports, a write takes effect next cycle
  uem_report uem_report_i (
    .clk_sys(clk_sys),
    .block_reset(block_reset),
    .err_detect(err_detect),
    .suppress(suppress_view),
    .fatality(fatality_view),
    .status_set(status_set),
    .fatal_msg(fatal_msg),
    .nonfatal_msg(nonfatal_msg),
    .header_log_load(header_log_load),
    .first_ptr_load(first_ptr_load),
    .first_ptr(first_ptr)
  );

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (block_reset);

  property p_masked_silent;
    !$past(block_reset) && ($past(err_detect & suppress_view) != uem_pkg::WORD_ZERO)
      && ($past(err_detect & ~suppress_view & uem_pkg::REPORTABLE_BITS) == uem_pkg::WORD_ZERO)
      |-> !header_log_load && !first_ptr_load && !fatal_msg && !nonfatal_msg;
  endproperty
  a_masked_silent: assert property (p_masked_silent) else $error("masked error produced a report");

  property p_status_follows;
    !$past(block_reset) |-> status_set == ($past(err_detect) & ~$past(suppress_view) & uem_pkg::REPORTABLE_BITS);
  endproperty
  a_status_follows: assert property (p_status_follows) else $error("status set differs from unmasked errors");

  property p_suppress_reset_zero;
    $fell(block_reset) |-> suppress_view == uem_pkg::SUPPRESS_RESET;
  endproperty
  a_suppress_reset_zero: assert property (@(posedge clk_sys) disable iff (1'b0) p_suppress_reset_zero)
    else $error("mask word not zero after reset");

  property p_fatality_reset;
    $fell(block_reset) |-> fatality_view == uem_pkg::FATALITY_RESET;
  endproperty
  a_fatality_reset: assert property (@(posedge clk_sys) disable iff (1'b0) p_fatality_reset)
    else $error("severity word wrong after reset");

  property p_mask_read;
    cfg_rd && hit_suppress |=> cfg_rd_valid && ((cfg_rdata & ~uem_pkg::WRITABLE_BITS) == uem_pkg::WORD_ZERO)
      && cfg_rdata == $past(suppress_view);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read shows read-only bits");

  property p_sev_read;
    cfg_rd && hit_fatality |=> cfg_rd_valid && cfg_rdata[uem_pkg::SURPRISE_DOWN_BIT] && cfg_rdata[0]
      && !cfg_rdata[uem_pkg::ACCESS_VIOLATION_BIT] && (cfg_rdata[31:22] == 10'h000) && (cfg_rdata[3:1] == 3'h0);
  endproperty
  a_sev_read: assert property (p_sev_read) else $error("severity read has wrong fixed bits");

  property p_lane_write;
    cfg_wr && hit_suppress && !cfg_be[2] |=> suppress_bits[23:16] == $past(suppress_bits[23:16]);
  endproperty
  a_lane_write: assert property (p_lane_write) else $error("disabled lane changed the mask");

  property p_write_takes;
    cfg_wr && hit_fatality && cfg_be[0]
      |=> fatality_view[uem_pkg::LINK_FAULT_BIT] == $past(cfg_wdata[uem_pkg::LINK_FAULT_BIT]);
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("severity write not stored");

  property p_fatal_class;
    !$past(block_reset)
      && ($past(err_detect & ~suppress_view & fatality_view & uem_pkg::REPORTABLE_BITS) != uem_pkg::WORD_ZERO)
      |-> fatal_msg;
  endproperty
  a_fatal_class: assert property (p_fatal_class) else $error("fatal error not reported fatal");

  property p_pin_reset;
    link_fundamental_reset ##1 link_fundamental_reset |=> block_reset;
  endproperty
  a_pin_reset: assert property (@(posedge clk_sys) disable iff (reset) p_pin_reset)
    else $error("pin reset did not reach registers");

  // the other two pins share the chain; checked apart so a swapped bit is caught
  property p_por_reset;
    power_on_reset ##1 power_on_reset |=> block_reset;
  endproperty
  a_por_reset: assert property (@(posedge clk_sys) disable iff (reset) p_por_reset)
    else $error("power-on reset did not reach registers");

  property p_global_reset;
    global_reset_input ##1 global_reset_input |=> block_reset;
  endproperty
  a_global_reset: assert property (@(posedge clk_sys) disable iff (reset) p_global_reset)
    else $error("global reset did not reach registers");

  // ****************************************
  // report class and pointer checks
  // ****************************************
  // an unmasked nonfatal error must not vanish into the fatal pulse alone
  property p_nonfatal_class;
    !$past(block_reset)
      && ($past(err_detect & ~suppress_view & ~fatality_view & uem_pkg::REPORTABLE_BITS) != uem_pkg::WORD_ZERO)
      |-> nonfatal_msg;
  endproperty
  a_nonfatal_class: assert property (p_nonfatal_class) else $error("nonfatal error not flagged");

  // a fatal pulse with no fatal cause would escalate a harmless error
  property p_fatal_only_due;
    !$past(block_reset)
      && ($past(err_detect & ~suppress_view & fatality_view & uem_pkg::REPORTABLE_BITS) == uem_pkg::WORD_ZERO)
      |-> !fatal_msg;
  endproperty
  a_fatal_only_due: assert property (p_fatal_only_due) else $error("fatal pulse without fatal cause");

  // the pointer names the lowest reported position and nothing below it
  property p_pointer_lowest;
    first_ptr_load |-> status_set[first_ptr]
      && ((status_set & ~(~uem_pkg::WORD_ZERO << first_ptr)) == uem_pkg::WORD_ZERO);
  endproperty
  a_pointer_lowest: assert property (p_pointer_lowest) else $error("first pointer not lowest error");

  property p_pointer_idle;
    !first_ptr_load |-> (first_ptr == uem_pkg::PTR_ZERO) && !header_log_load && (status_set == uem_pkg::WORD_ZERO);
  endproperty
  a_pointer_idle: assert property (p_pointer_idle) else $error("pointer or log moved with no error");

  // ****************************************
  // read path checks
  // ****************************************
  property p_unmapped_zero;
    cfg_rd && !hit_suppress && !hit_fatality |=> cfg_rd_valid && (cfg_rdata == uem_pkg::WORD_ZERO);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read returned data");

  // downstream may latch read data blindly, so idle cycles must show zero
  property p_rdata_idle;
    !cfg_rd_valid |-> cfg_rdata == uem_pkg::WORD_ZERO;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero while idle");

  property p_mask_write_lands;
    cfg_wr && hit_suppress && cfg_be[0]
      |=> suppress_view[uem_pkg::LINK_FAULT_BIT] == $past(cfg_wdata[uem_pkg::LINK_FAULT_BIT]);
  endproperty
  a_mask_write_lands: assert property (p_mask_write_lands) else $error("mask write not stored");

  c_mask_write: cover property (cfg_wr && hit_suppress && cfg_be == 4'hF);
  c_fatal_report: cover property (fatal_msg);
  c_nonfatal_report: cover property (nonfatal_msg);
  c_masked_error: cover property ((err_detect & suppress_view) != uem_pkg::WORD_ZERO);
  c_unmapped_read: cover property (cfg_rd && !hit_suppress && !hit_fatality);

endmodule : uem_regs
`default_nettype wire

// ===== uem_pkg.sv
// package: offsets, field layouts and reset values of the uncorrectable error mask/severity pair
package uem_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] SUPPRESS_OFFSET = 12'h108; // uncorrectable_error_suppress
  localparam logic [11:0] FATALITY_OFFSET = 12'h10C; // uncorrectable_error_fatality
  localparam int unsigned REG_WIDTH = 32;            // both registers are one word
  localparam int unsigned LANE_COUNT = 4;            // byte lanes per word
  localparam int unsigned PTR_WIDTH = 5;             // first error pointer width

  // ****************************************
  // field layouts
  // ****************************************
  // writable bits: 20:12 and 4, same positions in both registers
  localparam logic [31:0] WRITABLE_BITS = 32'h001FF010;
  // severity bits that always read one: surprise down (5) and reserved bit 0
  localparam logic [31:0] FATALITY_FIXED_ONES = 32'h00000021;
  // error positions that can really be reported (unsupported ones excluded)
  localparam logic [31:0] REPORTABLE_BITS = 32'h001FF010;
  localparam int unsigned LINK_FAULT_BIT = 4;        // link_layer_fault position
  localparam int unsigned SURPRISE_DOWN_BIT = 5;     // surprise_down position
  localparam int unsigned ACCESS_VIOLATION_BIT = 21; // access_control_violation position

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] SUPPRESS_RESET = 32'h00000000;
  localparam logic [31:0] FATALITY_RESET = 32'h00062031;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [7:0] LANE_ONES = 8'hFF;
  localparam logic [7:0] LANE_ZERO = 8'h00;
  localparam logic [4:0] PTR_ZERO = 5'h00;

endpackage : uem_pkg

// ===== uem_report.sv
// module: masks and classifies detected errors into registered report pulses
`timescale 1ns/1ps
`default_nettype none

module uem_report (
  // clock and reset
  input wire logic clk_sys,
  input wire logic block_reset,
  // error sources and controls
  input wire logic [31:0] err_detect,
  input wire logic [31:0] suppress,
  input wire logic [31:0] fatality,
  // report pulses
  output logic [31:0] status_set,
  output logic fatal_msg,
  output logic nonfatal_msg,
  output logic header_log_load,
  output logic first_ptr_load,
  output logic [4:0] first_ptr
);

  // ****************************************
  // next-value computation
  // ****************************************
  logic [31:0] live;          // unmasked, supported errors this cycle
  logic [31:0] next_status_set;
  logic next_fatal_msg;
  logic next_nonfatal_msg;
  logic next_header_log_load;
  logic next_first_ptr_load;
  logic [4:0] next_first_ptr;

  // a masked error leaves no trace at all: status, message, log, pointer
  always_comb begin
    live = err_detect & ~suppress & uem_pkg::REPORTABLE_BITS;
    next_status_set = live;
    next_fatal_msg = |(live & fatality);
    next_nonfatal_msg = |(live & ~fatality);
    next_header_log_load = |live;
    next_first_ptr_load = |live;
    next_first_ptr = uem_pkg::PTR_ZERO;
    // lowest index wins when several errors land together
    for (int i = 31; i >= 0; i--) begin
      if (live[i]) begin
        next_first_ptr = i[4:0];
      end
    end
  end

  // ****************************************
  // output registers
  // ****************************************
  // registered so every report leaves on a flop edge
  always_ff @(posedge clk_sys) begin
    if (block_reset) begin
      status_set <= uem_pkg::WORD_ZERO;
      fatal_msg <= 1'b0;
      nonfatal_msg <= 1'b0;
      header_log_load <= 1'b0;
      first_ptr_load <= 1'b0;
      first_ptr <= uem_pkg::PTR_ZERO;
    end else begin
      status_set <= next_status_set;
      fatal_msg <= next_fatal_msg;
      nonfatal_msg <= next_nonfatal_msg;
      header_log_load <= next_header_log_load;
      first_ptr_load <= next_first_ptr_load;
      first_ptr <= next_first_ptr;
    end
  end

endmodule : uem_report
`default_nettype wire

// ===== pcie_aer_uncorrectable_mask_severity_bench.sv
// testbench: self-checking bench for the uncorrectable error mask and severity pair
`timescale 1ns/1ps
`default_nettype none

module pcie_aer_uncorrectable_mask_severity_bench;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clk_sys;
  logic [3:0] rst_vec; // local, link, global, power-on
  logic cfg_wr, cfg_rd;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, err_detect, cfg_rdata, status_set;
  logic cfg_rd_valid, fatal_msg, nonfatal_msg, header_log_load, first_ptr_load;
  logic [4:0] first_ptr;
  logic [40:0] rep_now; // all report outputs side by side
  assign rep_now = {status_set, fatal_msg, nonfatal_msg, header_log_load, first_ptr_load, first_ptr};
  // bench model of both registers, kept apart from the package on purpose
  localparam logic [31:0] WR_BITS = 32'h001FF010;
  localparam logic [31:0] SEV_DEFAULT = 32'h00062031;
  logic [31:0] m, s, r;
  logic [31:0] rd_q[$];
  logic [40:0] rep_q[$];
  int num_errors = 0;
  int compares = 0;
  bit armed = 0;
  bit err_seen = 0;

  uem_regs uem_regs_i (
    .clk_sys(clk_sys), .reset(rst_vec[0]), .link_fundamental_reset(rst_vec[1]),
    .global_reset_input(rst_vec[2]), .power_on_reset(rst_vec[3]),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
    .err_detect(err_detect), .status_set(status_set), .fatal_msg(fatal_msg),
    .nonfatal_msg(nonfatal_msg), .header_log_load(header_log_load),
    .first_ptr_load(first_ptr_load), .first_ptr(first_ptr));

  // ****************************************
  // helpers
  // ****************************************
  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // expected report vector: only unmasked supported positions count
  function automatic logic [40:0] rep_exp(input logic [31:0] e);
    logic [31:0] v;
    logic [4:0] p;
    v = e & ~m & WR_BITS;
    p = 5'h00;
    for (int i = 31; i >= 0; i--) if (v[i]) p = i[4:0];
    return {v, |(v & s), |(v & ~s), |v, |v, p};
  endfunction : rep_exp

  task automatic check(input logic [40:0] got, input logic [40:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one cycle of traffic; expectations use the model before this write lands
  task automatic step(input logic wr, input logic rd, input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] d, input logic [31:0] e);
    logic [31:0] lm;
    @(posedge clk_sys);
    cfg_wr <= wr;
    cfg_rd <= rd;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    err_detect <= e;
    if (e != 32'h00000000) rep_q.push_back(rep_exp(e));
    if (rd) rd_q.push_back(a == 12'h108 ? m : (a == 12'h10C ? s : 32'h00000000));
    lm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & WR_BITS;
    if (wr && a == 12'h108) m = (m & ~lm) | (d & lm);
    if (wr && a == 12'h10C) s = (s & ~lm) | (d & lm);
  endtask : step

  // pulse one reset source; pins need time for their synchronisers
  task automatic do_reset(input int k);
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    err_detect <= 32'h00000000;
    rst_vec <= 4'h1 << k;
    repeat (4) @(posedge clk_sys);
    rst_vec <= 4'h0;
    repeat (3) @(posedge clk_sys);
    m = 32'h00000000;
    s = SEV_DEFAULT;
  endtask : do_reset

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // ****************************************
  // result watcher
  // ****************************************
  // reads and reports are settled by the falling edge
  always @(negedge clk_sys) begin
    if (armed && cfg_rd_valid === 1'b1) begin
      if (rd_q.size() == 0) check({9'h000, cfg_rdata}, 41'h1FFFFFFFFFF);
      else check({9'h000, cfg_rdata}, {9'h000, rd_q.pop_front()});
    end
    if (armed && err_seen) begin
      check(rep_now, rep_q.pop_front());
    end else if (armed) begin
      check(rep_now, 41'h00000000000);
    end
    err_seen = (err_detect != 32'h00000000);
  end

  // watchdog well past the expected run length
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata, err_detect} = '0;
    rst_vec = 4'h1;
    m = 32'h00000000;
    s = SEV_DEFAULT;
    r = 32'h000130F1;
    repeat (12) @(posedge clk_sys);
    rst_vec <= 4'h0;
    armed = 1;
    // defaults and unmapped places
    step(1'b0, 1'b1, 12'h108, 4'hF, 32'h0, 32'h0);
    step(1'b0, 1'b1, 12'h10C, 4'hF, 32'h0, 32'h0);
    step(1'b1, 1'b1, 12'h104, 4'hF, 32'hFFFFFFFF, 32'h0);
    // all ones, read in the same cycle returns the old word
    step(1'b1, 1'b1, 12'h108, 4'hF, 32'hFFFFFFFF, 32'h0);
    step(1'b1, 1'b1, 12'h10C, 4'hF, 32'hFFFFFFFF, 32'h0);
    step(1'b0, 1'b1, 12'h108, 4'hF, 32'h0, 32'h0);
    step(1'b0, 1'b1, 12'h10C, 4'hF, 32'h0, 32'h0);
    // each byte lane alone
    for (int i = 0; i < 4; i++) begin
      step(1'b1, 1'b0, 12'h108, 4'hF, 32'h0, 32'h0);
      step(1'b1, 1'b0, 12'h10C, 4'hF, 32'h0, 32'h0);
      step(1'b1, 1'b0, 12'h108, 4'h1 << i, 32'hFFFFFFFF, 32'h0);
      step(1'b1, 1'b1, 12'h10C, 4'h1 << i, 32'hFFFFFFFF, 32'h0);
      step(1'b0, 1'b1, 12'h108, 4'hF, 32'h0, 32'h0);
      step(1'b0, 1'b1, 12'h10C, 4'hF, 32'h0, 32'h0);
    end
    // every error position, once all nonfatal and once all fatal
    step(1'b1, 1'b0, 12'h108, 4'hF, 32'h0, 32'h0);
    for (int k = 0; k < 2; k++) begin
      step(1'b1, 1'b0, 12'h10C, 4'hF, k ? 32'hFFFFFFFF : 32'h0, 32'h0);
      for (int i = 0; i < 32; i++) step(1'b0, 1'b0, 12'h0, 4'h0, 32'h0, 32'h1 << i);
    end
    // mask write applies from the next cycle on
    step(1'b1, 1'b0, 12'h108, 4'hF, 32'h00040000, 32'h0);
    step(1'b1, 1'b0, 12'h108, 4'hF, 32'h0, 32'h00040000);
    step(1'b0, 1'b0, 12'h0, 4'h0, 32'h0, 32'h00040000);
    // random mixed traffic, several errors per cycle
    repeat (300) begin
      r = lfsr_next(r);
      step(r[0], r[1], r[3] ? (r[2] ? 12'h10C : 12'h108) : (r[2] ? 12'h110 : 12'h104),
           r[7:4], lfsr_next(r) ^ 32'h5A5A5A5A, r[8] ? {r[15:0], r[31:16]} : 32'h0);
    end
    // every reset source restores the defaults
    for (int k = 0; k < 4; k++) begin
      step(1'b1, 1'b0, 12'h108, 4'hF, 32'hFFFFFFFF, 32'h0);
      step(1'b1, 1'b0, 12'h10C, 4'hF, 32'h0, 32'h0);
      do_reset(k);
      step(1'b0, 1'b1, 12'h108, 4'hF, 32'h0, 32'h0);
      step(1'b0, 1'b1, 12'h10C, 4'hF, 32'h0, 32'h0);
    end
    repeat (4) step(1'b0, 1'b0, 12'h0, 4'h0, 32'h0, 32'h0);
    if (rd_q.size() != 0 || rep_q.size() != 0) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, rd_q.size() + rep_q.size(), 0);
    end
    finish_test();
  end
endmodule : pcie_aer_uncorrectable_mask_severity_bench

`default_nettype wire
